// *** bench/afgces_assertions.sv ***
`timescale 1ns/10ps
module afgces_assertions (
  // Clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [8:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Status and port state
  input wire logic        rateConvRatioBad,
  input wire logic        rateConvCustom,
  input wire logic        elementMatchingBad,
  input wire logic        densityClockBad,
  input wire logic        primaryIsController,
  input wire logic        secondaryIsController,
  input wire logic        primaryFsync
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire rdA = read && !waitrequest && address == 9'h0F0;
  wire rdB = read && !waitrequest && address == 9'h0F4;
  wire cfgW = write && !waitrequest && address == 9'h0DC && byteenable[0];
  wire conv = rateConvRatioBad && !rateConvCustom;

  a_wait_single: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_answer_bound: assert property ((read || write) && waitrequest |=>
    !waitrequest) else $error("request not answered after one wait");
  a_idle_wait: assert property (!(read || write) |=> waitrequest)
    else $error("waitrequest dropped without a request");
  a_upper_zero: assert property (read && !waitrequest |->
    readdata[31:8] == 24'h000000) else $error("read data upper not zero");
  a_ctrl_copy: assert property (cfgW |-> ##2
    primaryIsController == $past(writedata[4], 2) &&
    secondaryIsController == $past(writedata[3], 2))
    else $error("controller select not followed");
  a_err_a_resvd: assert property (rdA |-> readdata[6:5] == 2'h0 &&
    !readdata[0]) else $error("reserved error bits set");
  a_err_b_resvd: assert property (rdB |-> readdata[2:0] == 3'h0)
    else $error("reserved error bits set");
  a_conv_flag: assert property (conv [*4] ##1 (conv && rdA) |->
    readdata[4]) else $error("converter ratio flag missing");
  a_match_flag: assert property (elementMatchingBad [*4] ##1
    (elementMatchingBad && rdA) |-> readdata[3])
    else $error("element matching flag missing");
  a_density_flag: assert property (densityClockBad [*4] ##1
    (densityClockBad && rdA) |-> readdata[2])
    else $error("density clock flag missing");

  c_ratio_err: cover property (rdA && readdata[7]);
  c_fsync: cover property ($rose(primaryFsync));
  c_halt: cover property (rdB && readdata[3]);
endmodule : afgces_assertions

bind afgces_top afgces_assertions chk (.*);

// *** bench/afgces_dsp_model.sv ***
`timescale 1ns/10ps
module afgces_dsp_model (
  // Control from the bench
  input wire logic run,
  input wire logic audioRun,
  // Pins toward the device
  output logic     bclkPin,
  output logic     audioClk
);
  initial begin
    bclkPin = 1'b0;
    audioClk = 1'b0;
  end
  // Bit clock stands low while run is off, phase unrelated to clock
  always begin
    #43;
    bclkPin = run ? ~bclkPin : 1'b0;
    #37;
    bclkPin = run ? ~bclkPin : 1'b0;
  end
  always #44 audioClk = audioRun ? ~audioClk : audioClk;
endmodule : afgces_dsp_model

// *** bench/afgces_top_tb.sv ***
`timescale 1ns/10ps
module afgces_top_tb;
  import afgces_pkg::*;
  typedef struct packed {
    logic [6:0] idx;
    logic [7:0] wd;
    logic [7:0] rst;
    logic [7:0] exp;
  } afgces_row_t;
  localparam logic [7:0] RATIO = 8'h08;
  logic        clock, sys_rst, read, write, waitrequest, irq;
  logic [8:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable, bad;
  logic [1:0]  pinRun, bclkPin;
  logic        audioRun, audioPin, intBclk, custom;
  logic        priFs, secFs, priCtl, secCtl, priFwd, secFwd;
  logic [7:0]  q;
  int          numErrors = 0, nChecks = 0, cyc = 0, intCnt = 0, n;
  afgces_row_t rows[10] = '{
    '{7'h37, 8'hE1, 8'h20, 8'hE1}, '{7'h38, 8'h55, 8'h00, 8'h55},
    '{7'h39, 8'hAA, 8'h00, 8'hAA}, '{7'h3A, 8'h3C, 8'h00, 8'h3C},
    '{7'h3B, 8'hC3, 8'h00, 8'hC3}, '{7'h3C, 8'h9E, 8'h00, 8'h00},
    '{7'h3D, 8'hF8, 8'h00, 8'h00}, '{7'h40, 8'h9E, 8'h00, 8'h9E},
    '{7'h41, 8'hF8, 8'h00, 8'hF8}, '{7'h42, 8'hFF, 8'h00, 8'h00}};
  logic [6:0]  fIdx[4] = '{7'h3C, 7'h3C, 7'h3C, 7'h3D};
  logic [7:0]  fBit[4] = '{8'h10, 8'h08, 8'h04, 8'h20};
  logic [7:0]  hiTab[4] = '{8'h00, 8'h40, 8'h80, 8'hC0};

  afgces_top #(.CLK_STOP_CYCLES(200), .FS_HALT_CYCLES(64)) uut (
    .clock(clock), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .primaryBclkPin(bclkPin[0]), .secondaryBclkPin(bclkPin[1]),
    .audioClkPin(audioPin), .primaryIntBclk(intBclk),
    .secondaryIntBclk(intBclk), .rateConvRatioBad(bad[0]),
    .rateConvCustom(custom), .elementMatchingBad(bad[1]),
    .densityClockBad(bad[2]), .controllerClkRatioBad(bad[3]),
    .primaryFsync(priFs), .secondaryFsync(secFs), .primaryBclkFwd(priFwd),
    .secondaryBclkFwd(secFwd), .primaryIsController(priCtl),
    .secondaryIsController(secCtl), .irq(irq));
  afgces_dsp_model dspP (.run(pinRun[0]), .audioRun(audioRun),
    .bclkPin(bclkPin[0]), .audioClk(audioPin));
  afgces_dsp_model dspS (.run(pinRun[1]), .audioRun(1'b0),
    .bclkPin(bclkPin[1]), .audioClk());

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Internal bit clock: eight cycles a period, the pin's ten, so the
  // timebase choice shows in the frame length
  always @(posedge clock) begin
    intCnt <= (intCnt == 3) ? 0 : intCnt + 1;
    if (intCnt == 3) intBclk <= ~intBclk;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      numErrors++;
      reportAndStop();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e) begin
      numErrors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Request held until waitrequest is sampled low
  task bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
    @(posedge clock);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, d};
    read <= !w;
    write <= w;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task wr(input logic [6:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task rd(input logic [6:0] idx);
    bus(1'b0, idx, 8'h00);
  endtask : rd
  function logic fsOf(input int p);
    return p ? secFs : priFs;
  endfunction : fsOf
  // Cycles between two rising frame edges, after one settling frame
  task measure(input int p, output int cnt);
    repeat (2) begin
      while (fsOf(p) !== 1'b0) @(posedge clock);
      while (fsOf(p) !== 1'b1) @(posedge clock);
    end
    cnt = 0;
    while (fsOf(p) !== 1'b0) begin
      @(posedge clock);
      cnt++;
    end
    while (fsOf(p) !== 1'b1) begin
      @(posedge clock);
      cnt++;
    end
  endtask : measure
  task reportAndStop();
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : reportAndStop

  initial begin
    sys_rst = 1'b1;
    {read, write, custom, intBclk} = 4'h0;
    address = 9'h000;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    bad = 4'h0;
    pinRun = 2'b11;
    audioRun = 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].idx);
      chk(q, rows[i].rst);
      wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx);
      chk(q, rows[i].exp);
    end
    for (int i = 0; i < 4; i++) begin
      bad[i] <= 1'b1;
      repeat (4) @(posedge clock);
      rd(fIdx[i]);
      chk(q & fBit[i], fBit[i]);
      chk(irq, 1'b1);
      bad[i] <= 1'b0;
      rd(fIdx[i]);
      chk(q & fBit[i], fBit[i]);
      rd(fIdx[i]);
      chk(q & fBit[i], 8'h00);
    end
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    {bad[0], custom} <= 2'b11;
    repeat (4) @(posedge clock);
    rd(7'h3C);
    chk(q & 8'h10, 8'h00);
    {bad[0], custom} <= 2'b00;
    audioRun <= 1'b0;
    repeat (300) @(posedge clock);
    rd(7'h3C);
    chk(q & 8'h02, 8'h02);
    audioRun <= 1'b1;
    wr(7'h39, RATIO);
    wr(7'h3B, RATIO);
    wr(7'h37, 8'h38);
    repeat (4) @(posedge clock);
    chk({priCtl, secCtl}, 2'b11);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        wr(p ? 7'h3A : 7'h38, hiTab[c]);
        measure(p, n);
        chk(n, RATIO * (c < 2 ? 10 : 8));
        chk(p ? secFwd : priFwd, !hiTab[c][6]);
      end
    end
    wr(7'h38, 8'h01);
    wr(7'h39, 8'h00);
    measure(0, n);
    chk(n, 2560);
    wr(7'h38, 8'h00);
    repeat (8) @(posedge clock);
    rd(7'h3C);
    chk(q & 8'h80, 8'h80);
    wr(7'h3A, 8'h00);
    rd(7'h3D);
    pinRun[1] <= 1'b0;
    repeat (100) @(posedge clock);
    rd(7'h3D);
    chk(q & 8'h88, 8'h88);
    chk(irq, 1'b1);
    wr(7'h40, 8'h00);
    wr(7'h41, 8'h00);
    rd(7'h3C);
    rd(7'h3D);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    reportAndStop();
  end
endmodule : afgces_top_tb

// *** design/afgces_fsync_gen.sv ***
`timescale 1ns/10ps
`include "afgces_regs.svh"

module afgces_fsync_gen
  import afgces_pkg::*;
#(
  parameter int HALT_CYCLES = `AFGCES_FS_HALT_CYCLES
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          sys_rst,
  // Configuration
  input  wire logic          controller,
  input  wire logic          useInternal,
  input  wire logic          invert,
  input  wire afgces_ratio_t ratio,
  // Bit clock levels, already in this domain
  input  wire logic          extBclk,
  input  wire logic          intBclk,
  // Results
  output logic               fsync,
  output logic               bclkFwd,
  output logic               ratioErr,
  output logic               fsErr
);

  logic          prevFsBclk_r;
  afgces_ratio_t cnt_r;
  afgces_ratio_t cnt_nxt;
  afgces_ratio_t prevRatio_r;
  logic          wasRunning_r;
  logic [15:0]   idleCnt_r;
  logic [15:0]   idleCnt_nxt;
  logic          fsync_r;
  logic          bclkFwd_r;
  logic          ratioErr_r;
  logic          fsErr_r;

  wire logic          selBclk    = useInternal ? intBclk : extBclk; // [R1] [R4]
  wire logic          fsBclk     = selBclk ^ invert;                // [R2] [R5]
  wire logic          countEdge  = fsBclk & ~prevFsBclk_r;          // [R15]
  wire logic          ratioZero  = (ratio == 14'h0000);
  wire logic          running    = controller & ~ratioZero;         // [R13]
  wire afgces_ratio_t lastCount  = ratio - 14'h0001;
  wire afgces_ratio_t highCount  = afgces_ratio_t'((15'(ratio) + 15'h0001) >> 1);
  wire logic          wrap       = (cnt_r >= lastCount);
  wire logic          rateChange = running & wasRunning_r & (ratio != prevRatio_r);
  wire logic          haltHit    = running & ~countEdge &
                                   (idleCnt_r == 16'(HALT_CYCLES - 1));

  // Frame counter advances only on the chosen edge of the timebase
  assign cnt_nxt = !running ? 14'h0000 :
                   !countEdge ? cnt_r :
                   wrap ? 14'h0000 : cnt_r + 14'h0001;              // [R15]

  // Saturates, so haltHit stays true and a halt gives an error event every cycle
  assign idleCnt_nxt = (!running || countEdge) ? 16'h0000 :
                       haltHit ? idleCnt_r :
                       (idleCnt_r == 16'(HALT_CYCLES - 1)) ? idleCnt_r :
                       idleCnt_r + 16'h0001;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prevFsBclk_r <= 1'b0;
      cnt_r        <= 14'h0000;
      prevRatio_r  <= 14'h0000;
      wasRunning_r <= 1'b0;
      idleCnt_r    <= 16'h0000;
    end else begin
      prevFsBclk_r <= fsBclk;
      cnt_r        <= cnt_nxt;
      prevRatio_r  <= ratio;
      wasRunning_r <= running;
      idleCnt_r    <= idleCnt_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fsync_r    <= 1'b0;
      bclkFwd_r  <= 1'b0;
      ratioErr_r <= 1'b0;
      fsErr_r    <= 1'b0;
    end else begin
      fsync_r    <= running & (cnt_nxt < highCount);                // [R15]
      bclkFwd_r  <= selBclk;                                        // [R2] [R5]
      ratioErr_r <= controller & ratioZero;
      fsErr_r    <= rateChange | (haltHit & (idleCnt_r != 16'h0000));
    end
  end

  assign fsync    = fsync_r;
  assign bclkFwd  = bclkFwd_r;
  assign ratioErr = ratioErr_r;
  assign fsErr    = fsErr_r;

endmodule : afgces_fsync_gen

// *** design/afgces_pkg.sv ***
package afgces_pkg;

  typedef enum logic {
    AFGCES_BUS_IDLE,
    AFGCES_BUS_ACK
  } afgces_bus_t;

  typedef logic [7:0]  afgces_byte_t;
  typedef logic [13:0] afgces_ratio_t;

endpackage : afgces_pkg

// *** design/afgces_regs.svh ***
// Contract
// (R1) Primary internal timebase bit picks internal bit clock
// (R2) Primary invert flips polarity for frame sync only
// (R3) Primary ratio is upper six plus lower byte
// (R4) Secondary internal timebase bit picks internal bit clock
// (R5) Secondary invert flips polarity for frame sync only
// (R6) Secondary ratio is upper six plus lower byte
// (R7) Error A bit 7 flags frame sync ratio error
// (R8) Error A bit 4: converter ratio, not custom
// (R9) Error A bit 3 flags element matching rate
// (R10) Error A bit 2 flags density clock error
// (R11) Error A bit 1: audio clock stopped 1ms
// (R12) Software writes zero into reserved bits
// (R13) Controller select bit: 0 target, 1 controller
// (R14) Error B bits 7-3 ratio and frame errors
// (R15) One frame per ratio count of chosen edge
`ifndef AFGCES_REGS_SVH
`define AFGCES_REGS_SVH

// Register indices; byte address is four times the index
`define AFGCES_IDX_CTRL_SEL      7'h37
`define AFGCES_IDX_PRI_CTRL_HI   7'h38
`define AFGCES_IDX_PRI_RATIO_LO  7'h39
`define AFGCES_IDX_SEC_CTRL_HI   7'h3A
`define AFGCES_IDX_SEC_RATIO_LO  7'h3B
`define AFGCES_IDX_ERR_A         7'h3C
`define AFGCES_IDX_ERR_B         7'h3D
`define AFGCES_IDX_MASK_A        7'h40
`define AFGCES_IDX_MASK_B        7'h41

// Reset values
`define AFGCES_RST_CTRL_SEL      8'h20
`define AFGCES_RST_ZERO          8'h00

// Writable bits of the controller select register
`define AFGCES_CTRL_SEL_WMASK    8'hF9

// Field positions
`define AFGCES_BIT_INT_TIMEBASE  7
`define AFGCES_BIT_CLK_INVERT    6
`define AFGCES_BIT_PRI_CTRL      4
`define AFGCES_BIT_SEC_CTRL      3
`define AFGCES_BIT_A_FS_RATIO    7
`define AFGCES_BIT_A_RATE_CONV   4
`define AFGCES_BIT_A_ELEM_MATCH  3
`define AFGCES_BIT_A_DENSITY     2
`define AFGCES_BIT_A_CLK_STOP    1
`define AFGCES_BIT_B_PRI_RATIO   7
`define AFGCES_BIT_B_SEC_RATIO   6
`define AFGCES_BIT_B_CCLK_RATIO  5
`define AFGCES_BIT_B_PRI_FS      4
`define AFGCES_BIT_B_SEC_FS      3
`define AFGCES_ERR_A_MASK        8'h9E
`define AFGCES_ERR_B_MASK        8'hF8

// Timing
`define AFGCES_CLK_PERIOD_NS     8
`define AFGCES_CLK_STOP_US       1000
`define AFGCES_CLK_STOP_CYCLES   ((`AFGCES_CLK_STOP_US * 1000) / `AFGCES_CLK_PERIOD_NS)
`define AFGCES_FS_HALT_CYCLES    4096

`endif

// *** design/afgces_top.sv ***
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
`include "afgces_regs.svh"

module afgces_top
  import afgces_pkg::*;
#(
  parameter int CLK_STOP_CYCLES = `AFGCES_CLK_STOP_CYCLES,
  parameter int FS_HALT_CYCLES  = `AFGCES_FS_HALT_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [8:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Pins from the serial ports, asynchronous
  input  wire logic        primaryBclkPin,
  input  wire logic        secondaryBclkPin,
  input  wire logic        audioClkPin,
  // Internal bit clocks, same domain
  input  wire logic        primaryIntBclk,
  input  wire logic        secondaryIntBclk,
  // Status from neighbouring clock logic, same domain
  input  wire logic        rateConvRatioBad,
  input  wire logic        rateConvCustom,
  input  wire logic        elementMatchingBad,
  input  wire logic        densityClockBad,
  input  wire logic        controllerClkRatioBad,
  // Frame sync and port status
  output logic             primaryFsync,
  output logic             secondaryFsync,
  output logic             primaryBclkFwd,
  output logic             secondaryBclkFwd,
  output logic             primaryIsController,
  output logic             secondaryIsController,
  // Interrupt
  output logic             irq
);

  function automatic logic hitIndex(input logic [8:0] addr,
                                    input logic [6:0] idx);
    hitIndex = (addr == {idx, 2'b00});
  endfunction : hitIndex

  // Synchronisers for the three pins
  localparam int NPIN = 3;

  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinMeta_r;
  logic [NPIN-1:0] pinSync_r;

  assign pinRaw = {audioClkPin, secondaryBclkPin, primaryBclkPin};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : gSync
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          pinMeta_r[gi] <= 1'b0;
          pinSync_r[gi] <= 1'b0;
        end else begin
          pinMeta_r[gi] <= pinRaw[gi];
          pinSync_r[gi] <= pinMeta_r[gi];
        end
      end
    end
  endgenerate

  wire logic priBclkSync  = pinSync_r[0];
  wire logic secBclkSync  = pinSync_r[1];
  wire logic audioClkSync = pinSync_r[2];

  // Registers
  afgces_byte_t ctrlSel_r;
  afgces_byte_t priCtrlHi_r;
  afgces_byte_t priRatioLo_r;
  afgces_byte_t secCtrlHi_r;
  afgces_byte_t secRatioLo_r;
  afgces_byte_t errA_r;
  afgces_byte_t errA_nxt;
  afgces_byte_t errB_r;
  afgces_byte_t errB_nxt;
  afgces_byte_t maskA_r;
  afgces_byte_t maskB_r;
  afgces_bus_t  busState_r;
  logic [31:0]  readdata_r;
  logic         waitrequest_r;
  logic         irq_r;

  // Bus decode
  wire logic hCtrlSel  = hitIndex(address, `AFGCES_IDX_CTRL_SEL);
  wire logic hPriHi    = hitIndex(address, `AFGCES_IDX_PRI_CTRL_HI);
  wire logic hPriLo    = hitIndex(address, `AFGCES_IDX_PRI_RATIO_LO);
  wire logic hSecHi    = hitIndex(address, `AFGCES_IDX_SEC_CTRL_HI);
  wire logic hSecLo    = hitIndex(address, `AFGCES_IDX_SEC_RATIO_LO);
  wire logic hErrA     = hitIndex(address, `AFGCES_IDX_ERR_A);
  wire logic hErrB     = hitIndex(address, `AFGCES_IDX_ERR_B);
  wire logic hMaskA    = hitIndex(address, `AFGCES_IDX_MASK_A);
  wire logic hMaskB    = hitIndex(address, `AFGCES_IDX_MASK_B);

  wire logic inAck     = (busState_r == AFGCES_BUS_ACK);
  wire logic wrAccept  = inAck & write & byteenable[0];
  wire logic rdAccept  = inAck & read;
  wire afgces_byte_t wByte = writedata[7:0];

  // Unmapped addresses read as zero and ignore writes
  wire afgces_byte_t rdMux =
      hCtrlSel ? ctrlSel_r    :
      hPriHi   ? priCtrlHi_r  :
      hPriLo   ? priRatioLo_r :
      hSecHi   ? secCtrlHi_r  :
      hSecLo   ? secRatioLo_r :
      hErrA    ? errA_r       :
      hErrB    ? errB_r       :
      hMaskA   ? maskA_r      :
      hMaskB   ? maskB_r      : `AFGCES_RST_ZERO;

  // One wait state; address stays stable during the request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busState_r    <= AFGCES_BUS_IDLE;
      waitrequest_r <= 1'b1;
      readdata_r    <= 32'h00000000;
    end else begin
      unique case (busState_r)
        AFGCES_BUS_IDLE: begin
          if (read || write) begin
            busState_r    <= AFGCES_BUS_ACK;
            waitrequest_r <= 1'b0;
            readdata_r    <= {24'h000000, rdMux};
          end
        end
        AFGCES_BUS_ACK: begin
          busState_r    <= AFGCES_BUS_IDLE;
          waitrequest_r <= 1'b1;
        end
      endcase
    end
  end

  // Configuration writes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrlSel_r    <= `AFGCES_RST_CTRL_SEL;
      priCtrlHi_r  <= `AFGCES_RST_ZERO;
      priRatioLo_r <= `AFGCES_RST_ZERO;
      secCtrlHi_r  <= `AFGCES_RST_ZERO;
      secRatioLo_r <= `AFGCES_RST_ZERO;
      maskA_r      <= `AFGCES_RST_ZERO;
      maskB_r      <= `AFGCES_RST_ZERO;
    end else if (wrAccept) begin
      // Reserved bits are kept at zero whatever is written
      if (hCtrlSel) ctrlSel_r <= wByte & `AFGCES_CTRL_SEL_WMASK;  // [R12]
      if (hPriHi)   priCtrlHi_r  <= wByte;
      if (hPriLo)   priRatioLo_r <= wByte;
      if (hSecHi)   secCtrlHi_r  <= wByte;
      if (hSecLo)   secRatioLo_r <= wByte;
      if (hMaskA)   maskA_r <= wByte & `AFGCES_ERR_A_MASK;        // [R12]
      if (hMaskB)   maskB_r <= wByte & `AFGCES_ERR_B_MASK;        // [R12]
    end
  end

  // Port configuration
  wire logic priCtrl = ctrlSel_r[`AFGCES_BIT_PRI_CTRL];            // [R13]
  wire logic secCtrl = ctrlSel_r[`AFGCES_BIT_SEC_CTRL];            // [R13]
  wire afgces_ratio_t priRatio = {priCtrlHi_r[5:0], priRatioLo_r}; // [R3]
  wire afgces_ratio_t secRatio = {secCtrlHi_r[5:0], secRatioLo_r}; // [R6]

  logic priFsync;
  logic secFsync;
  logic priFwd;
  logic secFwd;
  logic priRatioErr;
  logic secRatioErr;
  logic priFsErr;
  logic secFsErr;

  afgces_fsync_gen #(
    .HALT_CYCLES (FS_HALT_CYCLES)
  ) uPrimary (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .controller  (priCtrl),
    .useInternal (priCtrlHi_r[`AFGCES_BIT_INT_TIMEBASE]),
    .invert      (priCtrlHi_r[`AFGCES_BIT_CLK_INVERT]),
    .ratio       (priRatio),
    .extBclk     (priBclkSync),
    .intBclk     (primaryIntBclk),
    .fsync       (priFsync),
    .bclkFwd     (priFwd),
    .ratioErr    (priRatioErr),
    .fsErr       (priFsErr)
  );

  afgces_fsync_gen #(
    .HALT_CYCLES (FS_HALT_CYCLES)
  ) uSecondary (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .controller  (secCtrl),
    .useInternal (secCtrlHi_r[`AFGCES_BIT_INT_TIMEBASE]),
    .invert      (secCtrlHi_r[`AFGCES_BIT_CLK_INVERT]),
    .ratio       (secRatio),
    .extBclk     (secBclkSync),
    .intBclk     (secondaryIntBclk),
    .fsync       (secFsync),
    .bclkFwd     (secFwd),
    .ratioErr    (secRatioErr),
    .fsErr       (secFsErr)
  );

  // Audio clock stop watchdog, counts cycles with no edge
  logic        audioPrev_r;
  logic [16:0] stopCnt_r;
  logic [16:0] stopCnt_nxt;
  logic        stopped_r;

  wire logic audioEdge = audioClkSync ^ audioPrev_r;
  wire logic stopLimit = (stopCnt_r == 17'(CLK_STOP_CYCLES - 1));
  wire logic stopHit   = ~audioEdge & stopLimit & ~stopped_r;       // [R11]

  assign stopCnt_nxt = audioEdge ? 17'h00000 :
                       stopLimit ? stopCnt_r : stopCnt_r + 17'h00001;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      audioPrev_r <= 1'b0;
      stopCnt_r   <= 17'h00000;
      stopped_r   <= 1'b0;
    end else begin
      audioPrev_r <= audioClkSync;
      stopCnt_r   <= stopCnt_nxt;
      stopped_r   <= audioEdge ? 1'b0 : (stopped_r | stopHit);
    end
  end

  // Error events
  afgces_byte_t setA;
  afgces_byte_t setB;
  afgces_byte_t clrA;
  afgces_byte_t clrB;

  always_comb begin
    setA = `AFGCES_RST_ZERO;
    setA[`AFGCES_BIT_A_FS_RATIO]   = priRatioErr | secRatioErr;      // [R7]
    setA[`AFGCES_BIT_A_RATE_CONV]  = rateConvRatioBad & ~rateConvCustom; // [R8]
    setA[`AFGCES_BIT_A_ELEM_MATCH] = elementMatchingBad;             // [R9]
    setA[`AFGCES_BIT_A_DENSITY]    = densityClockBad;                // [R10]
    setA[`AFGCES_BIT_A_CLK_STOP]   = stopHit;                        // [R11]
  end

  always_comb begin
    setB = `AFGCES_RST_ZERO;
    setB[`AFGCES_BIT_B_PRI_RATIO]  = priRatioErr;                    // [R14]
    setB[`AFGCES_BIT_B_SEC_RATIO]  = secRatioErr;                    // [R14]
    setB[`AFGCES_BIT_B_CCLK_RATIO] = controllerClkRatioBad;          // [R14]
    setB[`AFGCES_BIT_B_PRI_FS]     = priFsErr;                       // [R14]
    setB[`AFGCES_BIT_B_SEC_FS]     = secFsErr;                       // [R14]
  end

  // Only bits already shown to software are cleared, so a late event
  // survives the read; set wins over clear in the same cycle
  assign clrA = (rdAccept && hErrA) ? readdata_r[7:0] : `AFGCES_RST_ZERO;
  assign clrB = (rdAccept && hErrB) ? readdata_r[7:0] : `AFGCES_RST_ZERO;
  assign errA_nxt = ((errA_r & ~clrA) | setA) & `AFGCES_ERR_A_MASK;
  assign errB_nxt = ((errB_r & ~clrB) | setB) & `AFGCES_ERR_B_MASK;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      errA_r <= `AFGCES_RST_ZERO;
      errB_r <= `AFGCES_RST_ZERO;
    end else begin
      errA_r <= errA_nxt;
      errB_r <= errB_nxt;
    end
  end

  // Outputs, all from flip-flops
  logic priIsCtrl_r;
  logic secIsCtrl_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_r       <= 1'b0;
      priIsCtrl_r <= 1'b0;
      secIsCtrl_r <= 1'b0;
    end else begin
      irq_r       <= |(errA_nxt & maskA_r) | |(errB_nxt & maskB_r);
      priIsCtrl_r <= priCtrl;                                        // [R13]
      secIsCtrl_r <= secCtrl;                                        // [R13]
    end
  end

  assign readdata              = readdata_r;
  assign waitrequest           = waitrequest_r;
  assign primaryFsync          = priFsync;
  assign secondaryFsync        = secFsync;
  assign primaryBclkFwd        = priFwd;
  assign secondaryBclkFwd      = secFwd;
  assign primaryIsController   = priIsCtrl_r;
  assign secondaryIsController = secIsCtrl_r;
  assign irq                   = irq_r;

endmodule : afgces_top
